/* File: dv/apb_host.sv */
// apb host model that drives the flash control registers
`timescale 1ns/100ps
module apb_host
  import flash_pkg::*;
(
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // issue a command and poll status until complete
  task automatic run(input logic [7:0] c, output logic [31:0] st,
                     output logic [31:0] first);
    logic e;
    xfer(1'b1, OFF_COMMAND, {24'h000000, c}, st, e);
    xfer(1'b0, OFF_STATUS, 32'h00000000, first, e);
    st = first;
    while (st[0] !== 1'b1) xfer(1'b0, OFF_STATUS, 32'h00000000, st, e);
  endtask
  // load an address, single read, then verify
  task automatic arm(input logic [15:0] a);
    logic [31:0] r;
    logic [31:0] f;
    logic e;
    xfer(1'b1, OFF_ADDRESS, {16'h0000, a}, r, e);
    run(CMD_READ, r, f);
    run(CMD_VERIFY, r, f);
  endtask
endmodule

/* File: dv/testbench.sv */
// self-checking testbench for the flash control block
`timescale 1ns/100ps
module testbench
  import flash_pkg::*;
;
  logic pclk, presetn, nv_resetn, psel, penable, pwrite, pready, pslverr;
  logic boot, sdm, irq, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, st, f;
  logic [1:0] path;
  int n_fail = 0;
  int checks_done = 0;
  always #4 pclk = ~pclk;
  flash_control #(.ERASE_CYCLES_P(300), .MASS_ERASE_CYCLES_P(100),
    .SIGNATURE_CYCLES_P(33000)) DUT (.pclk(pclk), .presetn(presetn),
    .nv_resetn(nv_resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .access_path(path), .boot_mode_select_pin(boot),
    .serial_download_mode(sdm), .flash_irq(irq));
  apb_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h00000000, r, e);
    chk(r, exp);
  endtask
  task automatic protect(input logic [31:0] pv, input logic [31:0] key);
    host.arm(16'h0800);
    wr(OFF_KEYED, pv);
    wr(OFF_MODE, 32'h000000F0);
    wr(OFF_ADDRESS, {16'h0000, key[31:16]});
    wr(OFF_DATA, {16'h0000, key[15:0]});
    host.run(CMD_PROTECT, st, f);
  endtask
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #720000;
    n_fail++;
    final_report();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    nv_resetn = 1'b0;
    boot = 1'b0;
    path = 2'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    nv_resetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, sdm}, 32'h1);
    rd(OFF_STATUS, 32'h20);
    wr(OFF_STATUS, 32'h0000FFFF);
    rd(OFF_STATUS, 32'h20);
    wr(OFF_MODE, 32'h10);
    rd(OFF_MODE, 32'h10);
    wr(OFF_COMMAND, {24'h000000, CMD_PING});
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_STATUS, 32'h09);
    rd(OFF_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_MODE, 32'h00);
    host.run(CMD_PING, st, f);
    chk(st, 32'h01);
    host.run(8'h0D, st, f);
    chk(st, 32'h03);
    wr(OFF_COMMAND, 32'h07);
    rd(OFF_STATUS, 32'h20);
    wr(OFF_ADDRESS, 32'h0800);
    host.run(CMD_PAGE_ERASE, st, f);
    chk(st, 32'h21);
    host.arm(16'h0800);
    wr(OFF_DATA, 32'h0006);
    host.run(CMD_MASS_ERASE, st, f);
    chk({31'h0, f[2]}, 32'h1);
    chk(st, 32'h21);
    rd(OFF_COMMAND, 32'h07);
    wr(OFF_ADDRESS, 32'h0);
    wr(OFF_DATA, 32'h1234);
    host.run(CMD_WRITE, st, f);
    chk(st, 32'h21);
    wr(OFF_IMMEDIATE, 32'hFFFFFFFE);
    rd(OFF_IMMEDIATE, 32'hFFFFFFFE);
    for (int p = 0; p < 4; p++) begin
      path <= p[1:0];
      wr(OFF_DATA, 32'h0);
      host.run(CMD_WRITE, st, f);
      chk(st, 32'h23);
    end
    path <= PATH_DEBUG;
    wr(OFF_IMMEDIATE, 32'h7FFFFFFF);
    host.run(CMD_READ, st, f);
    chk(st, 32'h23);
    path <= 2'h0;
    host.run(CMD_READ, st, f);
    chk(st, 32'h21);
    rd(OFF_DATA, 32'h1234);
    wr(OFF_ADDRESS, 32'hF800);
    host.run(CMD_READ, st, f);
    chk(st, 32'h23);
    rd(8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(OFF_IMMEDIATE, 32'hFFFFFFFF);
    protect(32'hFFFFFFFE, 32'h13572468);
    chk(st, 32'h09);
    protect(32'hFFFFFFFC, 32'h13572468);
    chk(st, 32'h09);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, sdm}, 32'h1);
    wr(OFF_ADDRESS, 32'h0800);
    host.run(CMD_WRITE, st, f);
    chk(st, 32'h23);
    wr(OFF_ADDRESS, 32'h0);
    wr(OFF_DATA, 32'h0);
    for (int k = 0; k < 2; k++) begin
      host.run(CMD_PROTECT, st, f);
      chk(st, 32'h03);
    end
    host.run(CMD_PROTECT, st, f);
    chk(st, 32'h23);
    host.run(CMD_READ, st, f);
    rd(OFF_DATA, 32'hFFFF);
    final_report();
  end
endmodule

/* File: inc/flash_pkg.sv */
// shared constants and types for the flash control block
package flash_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned ARRAY_WORDS = 32768;
  localparam int unsigned USER_WORDS = 31744;
  localparam int unsigned PAGE_BITS = 8;
  localparam int unsigned WRITE_US = 20;
  localparam int unsigned WRITE_CYCLES = WRITE_US * CLK_MHZ;
  localparam int unsigned ERASE_MS = 20;
  localparam int unsigned ERASE_CYCLES = ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned MASS_ERASE_MS = 2480;
  localparam int unsigned MASS_ERASE_CYCLES = MASS_ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned SIGNATURE_CYCLES = 32778;
  localparam int unsigned ACCESS_CYCLES = 2;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_COMMAND = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  localparam logic [7:0] OFF_ADDRESS = 8'h10;
  localparam logic [7:0] OFF_SIGNATURE = 8'h14;
  localparam logic [7:0] OFF_KEYED = 8'h18;
  localparam logic [7:0] OFF_IMMEDIATE = 8'h1C;
  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned MODE_IRQ_EN_BIT = 4;
  localparam int unsigned MODE_KEY_HI = 7;
  localparam int unsigned MODE_KEY_LO = 4;
  localparam logic [3:0] KEY_ENABLE = 4'hF;
  localparam int unsigned PROT_READ_BIT = 31;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [31:0] PROT_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] PROT_LOCKED = 32'h00000000;
  localparam logic [31:0] KEY_ERASED = 32'hFFFFFFFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [15:0] MASS_ERASE_ENABLE = 16'h0006;
  localparam logic [4:0] KERNEL_GROUP = 5'h1F;
  localparam logic [1:0] KEY_LAST_TRY = 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] CMD_NULL = 8'h00;
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_ERASE_WRITE = 8'h03;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h05;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h06;
  localparam logic [7:0] CMD_BURST_READ = 8'h07;
  localparam logic [7:0] CMD_BURST_ERASE = 8'h09;
  localparam logic [7:0] CMD_SIGNATURE = 8'h0B;
  localparam logic [7:0] CMD_PROTECT = 8'h0C;
  localparam logic [7:0] CMD_PING = 8'h0F;
  localparam logic [1:0] PATH_PARALLEL = 2'h2;
  localparam logic [1:0] PATH_DEBUG = 2'h3;
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WALK = 2'b01,
    ST_WAIT = 2'b10
  } engine_e;
  typedef struct packed {
    logic [9:0] reserved;
    logic burst;
    logic spare;
    logic irq;
    logic busy;
    logic fail;
    logic done;
  } status_s;
  typedef struct packed {
    logic [7:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;
endpackage

/* File: rtl/flash_array.sv */
// flash cell array: erase sets a word, program only clears bits
`timescale 1ns/100ps
module flash_array
  import flash_pkg::*;
#(
  parameter int unsigned WORDS = ARRAY_WORDS,
  parameter int unsigned WIDTH = 16,
  parameter int unsigned AW = $clog2(WORDS)
) (
  input wire logic pclk,
  input wire logic wr_en,
  input wire logic wr_erase,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] cells [WORDS];
  logic [WIDTH-1:0] next_cell;

  assign next_cell = wr_erase ? {WIDTH{1'b1}} : (cells[addr] & wr_data);

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      cells[addr] <= next_cell;
    end
  end

  assign rd_data = cells[addr];

  chk_program_clears_only:
  assert property (@(posedge pclk) wr_en && !wr_erase |=>
    (rd_data & ~$past(rd_data)) == '0 || addr != $past(addr))
    else $error("program set a bit");
endmodule

/* File: rtl/flash_control.sv */
// flash control interface: apb registers, command engine, protection
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////
module flash_control
  import flash_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES_P = ERASE_CYCLES,
  parameter int unsigned MASS_ERASE_CYCLES_P = MASS_ERASE_CYCLES,
  parameter int unsigned SIGNATURE_CYCLES_P = SIGNATURE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic nv_resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] access_path,
  input wire logic boot_mode_select_pin,
  output logic serial_download_mode,
  output logic flash_irq
);
  apb_req_s req;
  status_s stat_view;
  engine_e state;
  logic take, take_wr, take_rd, mapped, start, finish, clr_status;
  logic [7:0] flash_mode, flash_command, new_cmd, op, last_op;
  logic [15:0] flash_data, flash_address, rd_word;
  logic [23:0] code_signature, sig_acc;
  logic [31:0] keyed_protection, immediate_protection, prot_active;
  logic [31:0] key_stored, prot_stored, wprot, wait_cnt, rdata_mux;
  logic key_locked, load_pending, armed, busy_q, done_q, fail_q;
  logic [1:0] key_fails;
  logic [2:0] rd_snap;
  logic op_fail, op_walked, cmd_failed, mem_wr, executes;
  logic [14:0] walk_idx, walk_last, mem_addr;
  logic [4:0] grp;
  logic kernel_hit, write_blocked, read_blocked, key_match, key_enable;
  logic [7:0] next_op;
  logic next_fail, next_walk;
  logic [31:0] next_wait;
  logic [14:0] next_first, next_last;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, registered answer
  assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
  assign take = psel && penable && pready;
  assign take_wr = take && req.pwrite;
  assign take_rd = take && !req.pwrite;
  assign mapped = (req.paddr[1:0] == 2'b00) && (req.paddr <= OFF_IMMEDIATE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      rd_snap <= '0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= !mapped;
        prdata <= req.pwrite ? '0 : rdata_mux;
        rd_snap <= {stat_view.irq, stat_view.fail, stat_view.done};
      end
    end
  end

  assign stat_view = '{
    reserved: '0,
    burst: (flash_command >= CMD_BURST_READ) && (flash_command <= CMD_BURST_ERASE),
    spare: 1'b0,
    irq: flash_irq,
    busy: busy_q,
    fail: fail_q,
    done: done_q
  };

  always_comb begin
    rdata_mux = '0;
    case (req.paddr)
      OFF_STATUS: rdata_mux = 32'(stat_view);
      OFF_MODE: rdata_mux = 32'(flash_mode);
      OFF_COMMAND: rdata_mux = 32'(flash_command);
      OFF_DATA: rdata_mux = 32'(flash_data);
      OFF_ADDRESS: rdata_mux = 32'(flash_address);
      OFF_SIGNATURE: rdata_mux = 32'(code_signature);
      OFF_KEYED: rdata_mux = keyed_protection;
      OFF_IMMEDIATE: rdata_mux = immediate_protection;
      default: rdata_mux = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection and command decode
  assign grp = flash_address[15:11];
  assign wprot = prot_active & immediate_protection;
  assign kernel_hit = grp == KERNEL_GROUP;
  assign write_blocked = kernel_hit || !wprot[grp];
  assign read_blocked = kernel_hit || (!wprot[PROT_READ_BIT] &&
    (access_path == PATH_PARALLEL || access_path == PATH_DEBUG));
  assign key_match = {flash_address, flash_data} == key_stored;
  assign key_enable = flash_mode[MODE_KEY_HI:MODE_KEY_LO] == KEY_ENABLE;
  assign new_cmd = req.pwdata[7:0];
  assign executes = (new_cmd >= CMD_READ && new_cmd <= CMD_MASS_ERASE) ||
    (new_cmd >= CMD_SIGNATURE && new_cmd <= CMD_PING);
  assign start = take_wr && req.paddr == OFF_COMMAND && !busy_q && executes;

  always_comb begin
    next_op = new_cmd;
    next_fail = 1'b0;
    next_walk = 1'b0;
    next_wait = 32'd1;
    next_first = {flash_address[15:9], {PAGE_BITS{1'b0}}};
    next_last = {flash_address[15:9], {PAGE_BITS{1'b1}}};
    case (new_cmd)
      CMD_READ, CMD_VERIFY: begin
        next_fail = read_blocked;
        next_wait = 32'(ACCESS_CYCLES);
      end
      CMD_WRITE: begin
        next_fail = write_blocked;
        next_wait = 32'(WRITE_CYCLES);
      end
      CMD_ERASE_WRITE: begin
        next_fail = write_blocked;
        next_walk = !write_blocked;
        next_wait = 32'(ERASE_CYCLES_P + WRITE_CYCLES);
      end
      CMD_PAGE_ERASE: begin
        next_fail = write_blocked;
        next_walk = !write_blocked;
        next_wait = 32'(ERASE_CYCLES_P);
      end
      CMD_MASS_ERASE: begin
        next_fail = !(armed && flash_data == MASS_ERASE_ENABLE);
        next_walk = !next_fail;
        next_wait = 32'(MASS_ERASE_CYCLES_P);
        next_first = '0;
        next_last = 15'(USER_WORDS - 1);
      end
      CMD_SIGNATURE: begin
        next_walk = 1'b1;
        next_wait = 32'(SIGNATURE_CYCLES_P);
        next_first = '0;
        next_last = 15'(ARRAY_WORDS - 1);
      end
      CMD_PROTECT: begin
        next_fail = !(armed && key_enable) || (key_locked && !key_match);
        next_wait = 32'(WRITE_CYCLES);
        if (key_locked && !key_match && key_fails == KEY_LAST_TRY) begin
          next_op = CMD_MASS_ERASE;
          next_walk = 1'b1;
          next_wait = 32'(MASS_ERASE_CYCLES_P);
          next_first = '0;
          next_last = 15'(USER_WORDS - 1);
        end
      end
      CMD_PING: next_fail = 1'b0;
      default: next_fail = 1'b1;
    endcase
    if (next_fail && !next_walk) begin
      next_wait = 32'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command engine
  assign finish = (state == ST_WAIT) && (wait_cnt <= 32'd1);
  assign cmd_failed = op_fail || (op == CMD_VERIFY && rd_word != flash_data);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      op <= CMD_NULL;
      op_fail <= 1'b0;
      op_walked <= 1'b0;
      wait_cnt <= '0;
      walk_idx <= '0;
      walk_last <= '0;
      sig_acc <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            op <= next_op;
            op_fail <= next_fail;
            op_walked <= next_walk;
            wait_cnt <= next_wait;
            walk_idx <= next_first;
            walk_last <= next_last;
            sig_acc <= '0;
            state <= next_walk ? ST_WALK : ST_WAIT;
          end
        end
        ST_WALK: begin
          if (wait_cnt > 32'd1) begin
            wait_cnt <= wait_cnt - 32'd1;
          end
          if (op == CMD_SIGNATURE) begin
            sig_acc <= sig_acc + 24'(rd_word);
          end
          if (walk_idx == walk_last) begin
            state <= ST_WAIT;
          end else begin
            walk_idx <= walk_idx + 15'd1;
          end
        end
        ST_WAIT: begin
          if (wait_cnt <= 32'd1) begin
            state <= ST_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 32'd1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign mem_wr = (state == ST_WALK && op != CMD_SIGNATURE) ||
    (finish && !op_fail && (op == CMD_WRITE || op == CMD_ERASE_WRITE));
  assign mem_addr = (state == ST_WALK) ? walk_idx : flash_address[15:1];

  flash_array #(
    .WORDS(ARRAY_WORDS),
    .WIDTH(16),
    .AW(15)
  ) u_array (
    .pclk(pclk),
    .wr_en(mem_wr),
    .wr_erase(state == ST_WALK),
    .addr(mem_addr),
    .wr_data(flash_data),
    .rd_data(rd_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status flags: hardware set wins over read clear
  assign clr_status = take_rd && req.paddr == OFF_STATUS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      flash_irq <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      done_q <= (done_q && !(clr_status && rd_snap[0])) || finish;
      fail_q <= (fail_q && !(clr_status && rd_snap[1])) || (finish && cmd_failed);
      flash_irq <= (flash_irq && !(clr_status && rd_snap[2])) ||
        (finish && flash_mode[MODE_IRQ_EN_BIT]);
      if (start) begin
        busy_q <= 1'b1;
      end else if (finish) begin
        busy_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_mode <= MODE_RESET;
    end else if (take_wr && req.paddr == OFF_MODE) begin
      flash_mode <= new_cmd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_command <= CMD_BURST_READ;
    end else if (take_wr && req.paddr == OFF_COMMAND && !busy_q) begin
      flash_command <= (new_cmd == CMD_NULL) ? CMD_BURST_READ : new_cmd;
    end else if (finish && op <= CMD_MASS_ERASE) begin
      flash_command <= CMD_BURST_READ;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_data <= '0;
      flash_address <= '0;
    end else begin
      if (take_wr && req.paddr == OFF_DATA && !busy_q) begin
        flash_data <= req.pwdata[15:0];
      end else if (finish && op == CMD_READ && !op_fail) begin
        flash_data <= rd_word;
      end
      if (take_wr && req.paddr == OFF_ADDRESS && !busy_q) begin
        flash_address <= req.pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_signature <= '0;
    end else if (finish && op == CMD_SIGNATURE) begin
      code_signature <= sig_acc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keyed_protection <= PROT_RESET;
      immediate_protection <= PROT_RESET;
    end else begin
      if (take_wr && req.paddr == OFF_KEYED) begin
        keyed_protection <= req.pwdata;
      end
      if (take_wr && req.paddr == OFF_IMMEDIATE) begin
        immediate_protection <= req.pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
      last_op <= CMD_NULL;
    end else if (finish) begin
      armed <= (op == CMD_VERIFY) && (last_op == CMD_READ);
      last_op <= op;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // after reset: load keyed protection, sample boot pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_pending <= 1'b1;
      prot_active <= PROT_LOCKED;
      serial_download_mode <= 1'b0;
    end else if (load_pending) begin
      load_pending <= 1'b0;
      prot_active <= prot_stored;
      serial_download_mode <= !boot_mode_select_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile key state, cleared by power-on or by a completed mass erase
  always_ff @(posedge pclk or negedge nv_resetn) begin
    if (!nv_resetn) begin
      key_stored <= KEY_ERASED;
      prot_stored <= PROT_RESET;
      key_locked <= 1'b0;
      key_fails <= '0;
    end else if (finish && op == CMD_MASS_ERASE && op_walked) begin
      key_stored <= KEY_ERASED;
      prot_stored <= PROT_RESET;
      key_locked <= 1'b0;
      key_fails <= '0;
    end else if (finish && op == CMD_PROTECT && !op_fail) begin
      key_stored <= {flash_address, flash_data};
      prot_stored <= keyed_protection;
      key_locked <= 1'b1;
      key_fails <= '0;
    end else if (start && new_cmd == CMD_PROTECT && key_locked && !key_match) begin
      key_fails <= key_fails + 2'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_busy_on_start:
  assert property (@(posedge pclk) disable iff (!presetn)
    start |=> busy_q && state != ST_IDLE) else $error("busy not raised on accept");

  chk_busy_ends_done:
  assert property (@(posedge pclk) disable iff (!presetn)
    finish |=> !busy_q && done_q) else $error("busy and complete out of step");

  chk_cmd_readback:
  assert property (@(posedge pclk) disable iff (!presetn)
    finish && op <= CMD_MASS_ERASE |=> flash_command == CMD_BURST_READ)
    else $error("command did not read back burst read");

  chk_wprot_fails:
  assert property (@(posedge pclk) disable iff (!presetn)
    start && new_cmd == CMD_WRITE && write_blocked |=> !mem_wr [*2] ##[0:2] fail_q)
    else $error("protected write not refused");

  chk_irq_gated:
  assert property (@(posedge pclk) disable iff (!presetn)
    finish && !flash_irq && !flash_mode[MODE_IRQ_EN_BIT] |=> !flash_irq)
    else $error("interrupt flag set while disabled");

  chk_read_block:
  assert property (@(posedge pclk) disable iff (!presetn)
    start && new_cmd == CMD_READ && read_blocked |=> op_fail ##1 $stable(flash_data))
    else $error("blocked read loaded data");

  chk_third_key:
  assert property (@(posedge pclk) disable iff (!presetn || !nv_resetn)
    start && new_cmd == CMD_PROTECT && key_locked && !key_match &&
    key_fails == KEY_LAST_TRY |=> state == ST_WALK && op == CMD_MASS_ERASE)
    else $error("third bad key did not erase");

  chk_mass_key:
  assert property (@(posedge pclk) disable iff (!presetn || !nv_resetn)
    finish && op == CMD_MASS_ERASE && op_walked |=> key_stored == KEY_ERASED && !key_locked)
    else $error("mass erase kept the key");

  chk_status_clear:
  assert property (@(posedge pclk) disable iff (!presetn)
    clr_status && rd_snap[0] && !finish |=> !done_q) else $error("complete not cleared");

  chk_boot_mode:
  assert property (@(posedge pclk) disable iff (!presetn)
    load_pending |=> serial_download_mode == !$past(boot_mode_select_pin))
    else $error("boot pin not captured");
endmodule
